// ### core/fast_count_pkg.sv
package fast_count_pkg;
  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] OUTCFG_OFS = 8'h04;
  localparam logic [7:0] CLEAR_OFS = 8'h08;
  localparam logic [7:0] THRESH1_OFS = 8'h0C;
  localparam logic [7:0] THRESH2_OFS = 8'h10;
  localparam logic [7:0] MOD0_OFS = 8'h14;
  localparam logic [7:0] RESULT0_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h34;
  // ----------------------------------------------------------------
  // field layout of the per-channel mode byte
  // ----------------------------------------------------------------
  localparam int CH_CFG_W = 8;
  localparam int FLD_FUNC = 0;
  localparam int FLD_SUB = 3;
  localparam int FLD_EDGE = 5;
  localparam int FLD_DIR = 6;
  localparam int FLD_EN = 7;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] OUTCFG_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // channel functions
  // ----------------------------------------------------------------
  localparam logic [2:0] FN_OFF = 3'h0;
  localparam logic [2:0] FN_FREQ = 3'h1;
  localparam logic [2:0] FN_TOTAL = 3'h2;
  localparam logic [2:0] FN_PULSE = 3'h3;
  localparam logic [2:0] FN_QUAD = 3'h4;
  localparam logic [2:0] FN_TOT_RESET = 3'h5;
  localparam logic [2:0] FN_MARKER = 3'h6;
  // pulse sub-modes
  localparam logic [1:0] PS_WIDTH_HI = 2'h0;
  localparam logic [1:0] PS_WIDTH_LO = 2'h1;
  localparam logic [1:0] PS_PER_RISE = 2'h2;
  localparam logic [1:0] PS_PER_FALL = 2'h3;
  // special output sources
  localparam logic [1:0] OUT_DIGITAL = 2'h0;
  localparam logic [1:0] OUT_PWM = 2'h1;
  localparam logic [1:0] OUT_COMPARE = 2'h2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_NS / 1000;
  // frequency windows in 1 us ticks: 10 ms, 100 ms, 500 ms, 1 s
  localparam logic [31:0] WIN_US_0 = 32'h0000_2710;
  localparam logic [31:0] WIN_US_1 = 32'h0001_86A0;
  localparam logic [31:0] WIN_US_2 = 32'h0007_A120;
  localparam logic [31:0] WIN_US_3 = 32'h000F_4240;
  // hertz scale per window
  localparam logic [6:0] WIN_MUL_0 = 7'h64;
  localparam logic [6:0] WIN_MUL_1 = 7'h0A;
  localparam logic [6:0] WIN_MUL_2 = 7'h02;
  localparam logic [6:0] WIN_MUL_3 = 7'h01;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

// ### core/fast_count_channel.sv
`timescale 1ns/1ps
// Summary of operation
// - four counter inputs, each frequency, totalize, pulse or quadrature
// - each counter result sits in a readable accumulator register
// - frequency mode writes cycles per second to the accumulator
// - four selectable frequency sample windows
// - totalize counts once per configured rising or falling edge
// - nonzero modulus wraps totalizer to zero after modulus minus one
// - zero modulus lets totalizer run the full 32-bit range
// - program clear bit holds totalizer at zero while set
// - inputs 3 and 4 reset totalizers 1 and 2 on chosen edge
// - hardware reset role only once its totalizer is configured
// - hardware reset applied within 100 us of its edge
// - outputs 1 and 2 go high when totalizer reaches threshold
// - each special output is digital, pwm or compare
// - threshold changes at run time; zero holds compare output low
// - pulse mode shows the last completed measurement
// - width modes count 1 us ticks high or low
// - period modes count 1 us ticks rising-rising or falling-falling
// - quadrature uses input pairs 1-2 and 3-4, counters 1 and 3
// - two direction settings for phase 1 leading phase 2
// - count-up on the four x4 quadrature edge cases
// - input 3 may be marker resetting quadrature counter 1
// - quadrature wraps to zero up, to modulus minus one down
// - one program bit clears, another loads modulus minus one
// - marker edge rising, falling or both zeroes quadrature count
module fast_count_channel
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // field pins and output sources
  input wire logic [3:0] I_COUNT_IN,
  input wire logic [1:0] I_DIGITAL_OUT,
  input wire logic [1:0] I_PWM_OUT,
  output logic O_SPECIAL_OUTPUT_ONE,
  output logic O_SPECIAL_OUTPUT_TWO
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [31:0] outcfg_reg;
  logic [3:0] clear_reg;
  logic [31:0] thresh_reg [2];
  logic [31:0] wrap_mod_reg [4];
  logic [31:0] acc_reg [4];
  logic [31:0] run_reg [4];
  logic [31:0] win_reg [4];
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic [5:0] tick_cnt_reg;
  logic [1:0] cmp_reg;
  fast_count_pkg::apb_req_s req;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  wire [3:0] idx = I_PADDR[5:2];
  // misaligned addresses hit no register
  wire aligned = I_PADDR[1:0] == 2'h0;
  wire in_mod = aligned && I_PADDR >= fast_count_pkg::MOD0_OFS
                && I_PADDR < fast_count_pkg::RESULT0_OFS;
  wire in_res = aligned && I_PADDR >= fast_count_pkg::RESULT0_OFS
                && I_PADDR < fast_count_pkg::STATUS_OFS;
  wire [1:0] mod_sel = 2'(idx - 4'h5);
  wire [1:0] res_sel = 2'(idx - 4'h9);
  wire known = aligned && I_PADDR <= fast_count_pkg::STATUS_OFS;

  assign req = '{I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA};
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = req.psel && req.penable && !known;

  // ----------------------------------------------------------------
  // 1 us tick and input synchroniser
  // ----------------------------------------------------------------
  // tick divider
  wire tick = tick_cnt_reg == 6'(fast_count_pkg::TICK_CYCLES - 1);
  wire [3:0] pin = sync2_reg;
  wire [3:0] rise = pin & ~prev_reg;
  wire [3:0] fall = ~pin & prev_reg;

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      tick_cnt_reg <= 6'h00;
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end
    else
    begin
      tick_cnt_reg <= tick ? 6'h00 : tick_cnt_reg + 6'h01;
      sync1_reg <= I_COUNT_IN;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      mode_reg <= fast_count_pkg::MODE_RST;
      outcfg_reg <= fast_count_pkg::OUTCFG_RST;
      clear_reg <= 4'h0;
      thresh_reg[0] <= 32'h0000_0000;
      thresh_reg[1] <= 32'h0000_0000;
    end
    else if (wr_en)
    begin
      if (I_PADDR == fast_count_pkg::MODE_OFS)
        mode_reg <= I_PWDATA;
      if (I_PADDR == fast_count_pkg::OUTCFG_OFS)
        outcfg_reg <= {28'h0, I_PWDATA[3:0]};
      if (I_PADDR == fast_count_pkg::CLEAR_OFS)
        clear_reg <= I_PWDATA[3:0];
      if (I_PADDR == fast_count_pkg::THRESH1_OFS)
        thresh_reg[0] <= I_PWDATA;
      if (I_PADDR == fast_count_pkg::THRESH2_OFS)
        thresh_reg[1] <= I_PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // per-channel counting
  // ----------------------------------------------------------------
  // per-channel function select
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      wire [7:0] cfg = mode_reg[g*8 +: 8];
      wire [2:0] func = cfg[fast_count_pkg::FLD_FUNC +: 3];
      wire [1:0] sub = cfg[fast_count_pkg::FLD_SUB +: 2];
      wire edge_fall = cfg[fast_count_pkg::FLD_EDGE];
      wire dir_dn = cfg[fast_count_pkg::FLD_DIR];
      wire [31:0] wmod = wrap_mod_reg[g];
      wire [31:0] wmax = wmod - 32'h1;
      wire cnt_edge = edge_fall ? fall[g] : rise[g];
      // hw reset from input g+2 for totalizers 1 and 2
      wire [7:0] rcfg = (g < 2) ? mode_reg[((g+2)%4)*8 +: 8] : 8'h00;
      wire rst_edge = rcfg[fast_count_pkg::FLD_EDGE] ? fall[(g+2)%4] : rise[(g+2)%4];
      // reset role honoured only when totalizer configured
      wire hw_rst = g < 2 && rcfg[2:0] == fast_count_pkg::FN_TOT_RESET
                    && func == fast_count_pkg::FN_TOTAL && rst_edge;
      // quadrature only on counters 1 and 3, phases g and g+1
      wire qa = pin[g];
      wire qb = pin[(g+1)%4];
      wire q_ok = (g == 0 || g == 2) && func == fast_count_pkg::FN_QUAD;
      wire fwd = (rise[g] && !qb) || (rise[(g+1)%4] && qa)
              || (fall[g] && qb) || (fall[(g+1)%4] && !qa);
      wire rev = (rise[g] && qb) || (rise[(g+1)%4] && !qa)
              || (fall[g] && !qb) || (fall[(g+1)%4] && qa);
      wire q_up = dir_dn ? rev : fwd;
      wire q_dn = dir_dn ? fwd : rev;
      // marker on input 3 for quadrature counter 1
      wire [7:0] mcfg = mode_reg[23:16];
      wire [1:0] msel = mcfg[fast_count_pkg::FLD_SUB +: 2];
      // marker edge: 0 rising, 1 falling, else both
      wire m_edge = msel == 2'h0 ? rise[2] : msel == 2'h1 ? fall[2] : (rise[2] | fall[2]);
      wire marker = g == 0 && mcfg[2:0] == fast_count_pkg::FN_MARKER && m_edge;
      wire [31:0] win_len = sub == 2'h0 ? fast_count_pkg::WIN_US_0
                          : sub == 2'h1 ? fast_count_pkg::WIN_US_1
                          : sub == 2'h2 ? fast_count_pkg::WIN_US_2 : fast_count_pkg::WIN_US_3;
      wire [6:0] win_mul = sub == 2'h0 ? fast_count_pkg::WIN_MUL_0
                         : sub == 2'h1 ? fast_count_pkg::WIN_MUL_1
                         : sub == 2'h2 ? fast_count_pkg::WIN_MUL_2 : fast_count_pkg::WIN_MUL_3;
      // pulse: gate level and closing edge
      wire p_lvl = sub == fast_count_pkg::PS_WIDTH_LO ? !pin[g] : pin[g];
      wire p_end = sub == fast_count_pkg::PS_WIDTH_HI ? fall[g]
                 : sub == fast_count_pkg::PS_WIDTH_LO ? rise[g]
                 : sub == fast_count_pkg::PS_PER_RISE ? rise[g] : fall[g];
      wire p_count = sub[1] || p_lvl;

      always_ff @(posedge I_REF_CLK)
      begin
        if (I_RST)
        begin
          acc_reg[g] <= 32'h0000_0000;
          run_reg[g] <= 32'h0000_0000;
          win_reg[g] <= 32'h0000_0000;
          wrap_mod_reg[g] <= 32'h0000_0000;
        end
        else
        begin
          if (wr_en && in_mod && mod_sel == 2'(g))
            wrap_mod_reg[g] <= I_PWDATA;
          unique case (func)
            fast_count_pkg::FN_FREQ:
            begin
              // edges per window scaled to hertz
              if (tick && win_reg[g] >= win_len - 32'h1)
              begin
                acc_reg[g] <= 32'(run_reg[g] * win_mul);
                run_reg[g] <= {31'h0, rise[g]};
                win_reg[g] <= 32'h0;
              end
              else
              begin
                run_reg[g] <= run_reg[g] + {31'h0, rise[g]};
                win_reg[g] <= win_reg[g] + {31'h0, tick};
              end
            end
            fast_count_pkg::FN_TOTAL:
            begin
              if (clear_reg[g])
                acc_reg[g] <= 32'h0;
              else if (hw_rst)
                acc_reg[g] <= 32'h0;
              else if (cnt_edge)
                acc_reg[g] <= (wmod != 32'h0 && acc_reg[g] >= wmax) ? 32'h0 : acc_reg[g] + 32'h1;
            end
            fast_count_pkg::FN_PULSE:
            begin
              if (p_end)
              begin
                acc_reg[g] <= run_reg[g];
                run_reg[g] <= 32'h0;
              end
              else if (tick && p_count)
                run_reg[g] <= run_reg[g] + 32'h1;
            end
            fast_count_pkg::FN_QUAD:
            begin
              if (!q_ok)
                acc_reg[g] <= 32'h0;
              else if (clear_reg[g])
                acc_reg[g] <= 32'h0;
              else if (clear_reg[(g+1)%4])
                acc_reg[g] <= wmax;
              else if (marker)
                acc_reg[g] <= 32'h0;
              else if (q_up)
                acc_reg[g] <= (wmod != 32'h0 && acc_reg[g] >= wmax) ? 32'h0 : acc_reg[g] + 32'h1;
              else if (q_dn)
                acc_reg[g] <= (wmod != 32'h0 && acc_reg[g] == 32'h0) ? wmax : acc_reg[g] - 32'h1;
            end
            default:
            begin
              acc_reg[g] <= acc_reg[g];
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // compare outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      cmp_reg <= 2'h0;
    else
    begin
      cmp_reg[0] <= thresh_reg[0] != 32'h0 && acc_reg[0] >= thresh_reg[0]
                    && mode_reg[2:0] == fast_count_pkg::FN_TOTAL;
      cmp_reg[1] <= thresh_reg[1] != 32'h0 && acc_reg[1] >= thresh_reg[1]
                    && mode_reg[10:8] == fast_count_pkg::FN_TOTAL;
    end
  end

  assign O_SPECIAL_OUTPUT_ONE = outcfg_reg[1:0] == fast_count_pkg::OUT_COMPARE ? cmp_reg[0]
    : outcfg_reg[1:0] == fast_count_pkg::OUT_PWM ? I_PWM_OUT[0] : I_DIGITAL_OUT[0];
  assign O_SPECIAL_OUTPUT_TWO = outcfg_reg[3:2] == fast_count_pkg::OUT_COMPARE ? cmp_reg[1]
    : outcfg_reg[3:2] == fast_count_pkg::OUT_PWM ? I_PWM_OUT[1] : I_DIGITAL_OUT[1];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // accumulators readable any time
  always_comb
  begin
    O_PRDATA = 32'h0;
    if (I_PADDR == fast_count_pkg::MODE_OFS)
      O_PRDATA = mode_reg;
    else if (I_PADDR == fast_count_pkg::OUTCFG_OFS)
      O_PRDATA = outcfg_reg;
    else if (I_PADDR == fast_count_pkg::CLEAR_OFS)
      O_PRDATA = {28'h0, clear_reg};
    else if (I_PADDR == fast_count_pkg::THRESH1_OFS)
      O_PRDATA = thresh_reg[0];
    else if (I_PADDR == fast_count_pkg::THRESH2_OFS)
      O_PRDATA = thresh_reg[1];
    else if (in_mod)
      O_PRDATA = wrap_mod_reg[mod_sel];
    else if (in_res)
      O_PRDATA = acc_reg[res_sel];
    else if (I_PADDR == fast_count_pkg::STATUS_OFS)
      O_PRDATA = {24'h0, 2'h0, cmp_reg, pin};
  end

endmodule

// ### tb/fast_count_channel_checker.sv
`timescale 1ns/1ps
module fast_count_channel_checker
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // field pins and output sources
  input wire logic [3:0] I_COUNT_IN,
  input wire logic [1:0] I_DIGITAL_OUT,
  input wire logic [1:0] I_PWM_OUT,
  input wire logic O_SPECIAL_OUTPUT_ONE,
  input wire logic O_SPECIAL_OUTPUT_TWO
);
  // ----------------------------------------------------------------
  // shadow of the written configuration
  // ----------------------------------------------------------------
  logic [31:0] mode_reg, ocfg_reg, clr_reg, thr_reg;
  wire acc = I_PSEL && I_PENABLE;
  wire wr = acc && I_PWRITE;
  wire rd0 = acc && !I_PWRITE && I_PADDR == fast_count_pkg::RESULT0_OFS;
  wire tot0 = mode_reg[2:0] == fast_count_pkg::FN_TOTAL;
  wire cmp1 = ocfg_reg[1:0] == fast_count_pkg::OUT_COMPARE;
  always_ff @(posedge I_REF_CLK)
    if (I_RST)
      {mode_reg, ocfg_reg, clr_reg, thr_reg} <= '0;
    else if (wr && I_PADDR == fast_count_pkg::MODE_OFS)
      mode_reg <= I_PWDATA;
    else if (wr && I_PADDR == fast_count_pkg::OUTCFG_OFS)
      ocfg_reg <= I_PWDATA;
    else if (wr && I_PADDR == fast_count_pkg::CLEAR_OFS)
      clr_reg <= I_PWDATA;
    else if (wr && I_PADDR == fast_count_pkg::THRESH1_OFS)
      thr_reg <= I_PWDATA;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  a_ready_zero_wait: assert property (acc |-> O_PREADY)
    else $error("access phase not answered at once");
  a_unmapped_error: assert property (acc && I_PADDR > fast_count_pkg::STATUS_OFS
    |-> O_PSLVERR) else $error("unmapped access not refused");
  a_mapped_no_error: assert property (acc && I_PADDR <= fast_count_pkg::STATUS_OFS
    && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR) else $error("mapped access refused");
  a_digital_pass: assert property (ocfg_reg[1:0] == fast_count_pkg::OUT_DIGITAL
    |-> O_SPECIAL_OUTPUT_ONE == I_DIGITAL_OUT[0]) else $error("output one not digital");
  a_pwm_pass: assert property (ocfg_reg[3:2] == fast_count_pkg::OUT_PWM
    |-> O_SPECIAL_OUTPUT_TWO == I_PWM_OUT[1]) else $error("output two not pwm");
  a_zero_thresh_low: assert property ((cmp1 && thr_reg == 32'h0)[*3]
    |-> !O_SPECIAL_OUTPUT_ONE) else $error("compare high with zero threshold");
  a_clear_holds: assert property (clr_reg[0] && $past(clr_reg[0]) && tot0 && $past(tot0)
    && rd0 |-> O_PRDATA == 32'h0) else $error("cleared totalizer not zero");
  a_status_sync: assert property (acc && !I_PWRITE
    && I_PADDR == fast_count_pkg::STATUS_OFS |-> O_PRDATA[3:0] == $past(I_COUNT_IN, 2))
    else $error("pin status not two flops late");
  a_compare_reached: assert property (rd0 && tot0 && cmp1 && thr_reg != 32'h0
    && O_PRDATA >= thr_reg |-> ##[0:2] O_SPECIAL_OUTPUT_ONE) else $error("compare not set");
endmodule
bind fast_count_channel fast_count_channel_checker i_chk
(
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_COUNT_IN(I_COUNT_IN),
  .I_DIGITAL_OUT(I_DIGITAL_OUT), .I_PWM_OUT(I_PWM_OUT),
  .O_SPECIAL_OUTPUT_ONE(O_SPECIAL_OUTPUT_ONE), .O_SPECIAL_OUTPUT_TWO(O_SPECIAL_OUTPUT_TWO)
);

// ### tb/field_source_model.sv
`timescale 1ns/1ps
module field_source_model
(
  // source clock
  input wire logic i_clk,
  // field pins
  output logic [3:0] o_pins
);
  // ----------------------------------------------------------------
  // pulse and encoder source
  // ----------------------------------------------------------------
  initial o_pins = 4'h0;
  // positive logic, edges at least 100 us apart
  task automatic drive(input logic [3:0] v, input int us);
    int n;
    n = (us < 100) ? 100 : us;
    o_pins <= v;
    repeat (n * fast_count_pkg::TICK_CYCLES) @(posedge i_clk);
  endtask
endmodule

// ### tb/test_high_speed_input_counter.sv
`timescale 1ns/1ps
module test_high_speed_input_counter;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  fast_count_pkg::apb_req_s req;
  logic clk, rst, pready, pslverr, o1, o2, err;
  logic [31:0] rdata, rd, e, seed;
  logic [3:0] pins;
  logic [1:0] dig, pwm;
  logic [3:0] qs [5] = '{4'h1, 4'h3, 4'h2, 4'h0, 4'h2};
  int n_fail = 0;
  int comparisons = 0;
  fast_count_channel i_dut
  (
    .I_REF_CLK(clk), .I_RST(rst),
    .I_PSEL(req.psel), .I_PENABLE(req.penable), .I_PWRITE(req.pwrite),
    .I_PADDR(req.paddr), .I_PWDATA(req.pwdata),
    .O_PRDATA(rdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_COUNT_IN(pins), .I_DIGITAL_OUT(dig), .I_PWM_OUT(pwm),
    .O_SPECIAL_OUTPUT_ONE(o1), .O_SPECIAL_OUTPUT_TWO(o2)
  );
  field_source_model i_src
  (
    .i_clk(clk),
    .o_pins(pins)
  );
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] v, m, input logic dn);
    if (dn)
      return (v == 32'h0) ? m - 32'h1 : v - 32'h1;
    return (m != 32'h0 && v == m - 32'h1) ? 32'h0 : v + 32'h1;
  endfunction
  function automatic logic [31:0] near(input logic [31:0] got, want);
    return (got + 32'h1 >= want && got <= want + 32'h1) ? want : got;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = rdata;
    err = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse(input logic [3:0] v);
    i_src.drive(v, 100);
    i_src.drive(4'h0, 100);
  endtask
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    req = '0;
    rst = 1'b1;
    dig = 2'h0;
    pwm = 2'h0;
    seed = 32'h0001_7018;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(fast_count_pkg::MODE_OFS, fast_count_pkg::MODE_RST);
    rdchk(fast_count_pkg::OUTCFG_OFS, fast_count_pkg::OUTCFG_RST);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h0);
    seed = xs(seed);
    apb(1'b0, 8'h80 | (seed[7:0] & 8'h7C), 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, fast_count_pkg::MOD0_OFS | 8'h01, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    rdchk(fast_count_pkg::MOD0_OFS, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      wr(fast_count_pkg::OUTCFG_OFS, {28'h0, 2'(k), 2'(k)});
      repeat (4)
      begin
        @(posedge clk);
        seed = xs(seed);
        dig <= seed[1:0];
        pwm <= seed[3:2];
        #1;
        check({o2, o1}, k == 0 ? dig : k == 1 ? pwm : 32'h0);
      end
    end
    wr(fast_count_pkg::MODE_OFS, 32'h1300_0300);
    i_src.drive(4'hA, 150);
    i_src.drive(4'h0, 120);
    i_src.drive(4'hA, 100);
    rdchk(fast_count_pkg::STATUS_OFS, 32'h0000_000A);
    apb(1'b0, fast_count_pkg::RESULT0_OFS + 8'h04, 32'h0);
    check(near(rd, 32'h96), 32'h96);
    apb(1'b0, fast_count_pkg::RESULT0_OFS + 8'h0C, 32'h0);
    check(near(rd, 32'h10E), 32'h10E);
    i_src.drive(4'h0, 100);
    wr(fast_count_pkg::MODE_OFS, 32'h0005_0002);
    wr(fast_count_pkg::OUTCFG_OFS, 32'h0000_0002);
    wr(fast_count_pkg::THRESH1_OFS, 32'h0000_0002);
    wr(fast_count_pkg::MOD0_OFS, 32'h0000_0003);
    e = 32'h0;
    for (int k = 1; k <= 4; k++)
    begin
      pulse(4'h1);
      e = nxt(e, 32'h3, 1'b0);
      rdchk(fast_count_pkg::RESULT0_OFS, e);
      check({31'h0, o1}, {31'h0, k == 2});
      if (k == 2)
        wr(fast_count_pkg::THRESH1_OFS, 32'h0);
    end
    i_src.drive(4'h4, 100);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h0);
    i_src.drive(4'h0, 100);
    pulse(4'h1);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h1);
    wr(fast_count_pkg::CLEAR_OFS, 32'h1);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h0);
    pulse(4'h1);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h0);
    wr(fast_count_pkg::MODE_OFS, 32'h0006_0004);
    wr(fast_count_pkg::MOD0_OFS, 32'h0000_0004);
    wr(fast_count_pkg::CLEAR_OFS, 32'h0);
    e = 32'h0;
    foreach (qs[k])
    begin
      i_src.drive(qs[k], 100);
      e = nxt(e, 32'h4, k == 4);
      rdchk(fast_count_pkg::RESULT0_OFS, e);
    end
    wr(fast_count_pkg::CLEAR_OFS, 32'h1);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h0);
    wr(fast_count_pkg::CLEAR_OFS, 32'h2);
    rdchk(fast_count_pkg::RESULT0_OFS, nxt(32'h0, 32'h4, 1'b1));
    wr(fast_count_pkg::CLEAR_OFS, 32'h0);
    i_src.drive(4'h6, 100);
    rdchk(fast_count_pkg::RESULT0_OFS, 32'h0);
    complete_run;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule
